// *** core/rapc_top.sv ***
// relay control points and analog scanner mapping behind an apb slave
// assumes a 100 MHz pclk; analog samples arrive as 10-bit unsigned codes
`timescale 1ns/10ps
`include "rapc_regs.svh"
module rapc_top
   import rapc_pkg::*;
#(
   parameter int PULSE_CYC = `RAPC_PULSE_CYC,
   parameter int SEC_CYC = `RAPC_SEC_CYC,
   parameter int BLINK_CYC = `RAPC_BLINK_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic board_present,
   input wire logic [9:0] analog_sample,
   output logic [3:0] analog_sel,
   output logic [15:0] relay_out,
   output logic fail_led
);
   logic [2:0] rcs_reg;
   logic [3:0] ras_reg;
   logic [15:0] mom_reg;
   logic [7:0] diff_reg;
   logic [7:0] hold_reg;
   logic [15:0] relay_reg;
   logic [15:0] stat_reg;
   logic [15:0] valid_reg;
   logic [31:0] pulse_cnt [0:15];
   logic [39:0] stat_cnt [0:15];
   logic [9:0] value_reg [0:15];
   logic [4:0] range_rd;
   logic [3:0] scan_idx;
   logic [31:0] rdata_next;
   rapc_fail_t fail_reg;
   logic [31:0] blink_cnt;
   logic [1:0] blink_num;

   logic wr;
   logic cmd_hit;
   logic cmd_on;
   logic [3:0] cmd_pt;
   logic range_we;
   logic range_clr;
   logic [15:0] pos_map;
   logic [39:0] hold_cyc;

   // position p is valid unless it is the partner of a differential input
   function automatic logic [15:0] valid_map(input logic [7:0] d);
      valid_map = {~d, 8'hFF};
   endfunction : valid_map

   // mapping of a 10-bit unsigned sample onto 000..999: scaled when bip is set, clamped otherwise
   function automatic logic [9:0] encode(input logic [9:0] s,
                                         input logic bip);
      logic [19:0] p;
      p = 20'h0_0000;
      if (bip)
      begin
         p = 20'(s) * 20'(`RAPC_BIP_FULL) / 20'd1023;
         encode = p[9:0];
      end
      else
         encode = (s > `RAPC_BIP_FULL) ? `RAPC_BIP_FULL : s;
   endfunction : encode

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr = psel && penable && pwrite;
   assign cmd_hit = wr && paddr == `RAPC_OFF_CMD
      && pwdata[`RAPC_CMD_VALID]
      && pwdata[`RAPC_CMD_SCAN_LSB +: 3] == rcs_reg
      && rcs_reg >= `RAPC_RCS_MIN && rcs_reg <= `RAPC_RCS_MAX;
   assign cmd_on = pwdata[`RAPC_CMD_ON];
   assign cmd_pt = pwdata[`RAPC_CMD_PT_LSB +: 4];
   assign range_we = wr && paddr == `RAPC_OFF_RANGE && ras_reg != 4'd0
      && pwdata[3:0] <= `RAPC_RANGE_MAX;
   assign range_clr = wr && paddr == `RAPC_OFF_CTRL
      && pwdata[`RAPC_CTRL_RAS_LSB +: 4] == 4'd0;
   assign pos_map = valid_map(diff_reg);
   // wide enough for any hold setting without wrapping
   assign hold_cyc = 40'(SEC_CYC) * 40'(hold_reg);

   rapc_range_mem u_mem
   (
      .pclk(pclk),
      .presetn(presetn),
      .we(range_we),
      .clr(range_clr),
      .waddr(pwdata[11:8]),
      .wdata(pwdata[4:0]),
      .raddr(scan_idx),
      .rdata(range_rd)
   );

   // configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rcs_reg <= 3'd0;
         ras_reg <= 4'd0;
         mom_reg <= 16'h0000;
         diff_reg <= 8'h00;
         hold_reg <= `RAPC_HOLD_RST;
      end
      else if (wr)
      begin
         case (paddr)
            `RAPC_OFF_CTRL:
            begin
               rcs_reg <= pwdata[`RAPC_CTRL_RCS_LSB +: 3];
               if (pwdata[`RAPC_CTRL_RAS_LSB +: 4] <= `RAPC_RAS_MAX)
                  ras_reg <= pwdata[`RAPC_CTRL_RAS_LSB +: 4];
            end
            `RAPC_OFF_MOM: mom_reg <= pwdata[15:0];
            `RAPC_OFF_DIFF: diff_reg <= pwdata[7:0];
            `RAPC_OFF_HOLD: hold_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // relay and status per point
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay_reg <= 16'h0000;
         stat_reg <= 16'h0000;
         for (int i = 0; i < 16; i++)
         begin
            pulse_cnt[i] <= 32'h0000_0000;
            stat_cnt[i] <= 40'h00_0000_0000;
         end
      end
      else
      begin
         for (int i = 0; i < 16; i++)
         begin
            if (cmd_hit && cmd_pt == 4'(i) && !mom_reg[i])
            begin
               relay_reg[i] <= cmd_on;
               stat_reg[i] <= cmd_on;
            end
            else if (cmd_hit && cmd_pt == 4'(i) && cmd_on)
            begin
               relay_reg[i] <= 1'b1;
               pulse_cnt[i] <= 32'(PULSE_CYC - 1);
               stat_reg[i] <= 1'b1;
               if (hold_cyc != 40'h00_0000_0000)
                  stat_cnt[i] <= hold_cyc - 40'd1;
               else
                  stat_cnt[i] <= 40'h00_0000_0000;
            end
            // momentary OFF falls through, timers keep running
            else if (mom_reg[i])
            begin
               if (pulse_cnt[i] != 32'h0000_0000)
                  pulse_cnt[i] <= pulse_cnt[i] - 1;
               else
                  relay_reg[i] <= 1'b0;
               if (stat_cnt[i] != 40'h00_0000_0000)
                  stat_cnt[i] <= stat_cnt[i] - 40'd1;
               else
                  stat_reg[i] <= 1'b0;
            end
            else
               stat_reg[i] <= relay_reg[i];
         end
      end
   end

   // analog scan of positions 0..15; memory read is one cycle late
   logic [3:0] scan_d;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scan_idx <= 4'd0;
         scan_d <= 4'd0;
         valid_reg <= 16'h0000;
         for (int i = 0; i < 16; i++)
            value_reg[i] <= 10'h000;
      end
      else
      begin
         scan_idx <= scan_idx + 4'd1;
         scan_d <= scan_idx;
         if (ras_reg != 4'd0 && board_present)
            valid_reg <= pos_map;
         else
            valid_reg <= 16'h0000;
         if (pos_map[scan_d])
            value_reg[scan_d] <= encode(analog_sample, range_rd[4]);
         else
            value_reg[scan_d] <= 10'h000;
      end
   end
   assign analog_sel = scan_d;

   // fail indicator: three blinks then a gap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fail_reg <= RAPC_F_IDLE;
         blink_cnt <= 32'h0000_0000;
         blink_num <= 2'd0;
      end
      else if (ras_reg == 4'd0 || board_present)
      begin
         fail_reg <= RAPC_F_IDLE;
         blink_cnt <= 32'h0000_0000;
         blink_num <= 2'd0;
      end
      else if (blink_cnt != 32'h0000_0000)
         blink_cnt <= blink_cnt - 1;
      else
      begin
         blink_cnt <= 32'(BLINK_CYC - 1);
         case (fail_reg)
            RAPC_F_IDLE: fail_reg <= RAPC_F_ON;
            RAPC_F_ON: fail_reg <= RAPC_F_OFF;
            RAPC_F_OFF:
            begin
               if (blink_num == 2'd2)
               begin
                  blink_num <= 2'd0;
                  fail_reg <= RAPC_F_GAP;
                  blink_cnt <= 32'(4 * BLINK_CYC - 1);
               end
               else
               begin
                  blink_num <= blink_num + 2'd1;
                  fail_reg <= RAPC_F_ON;
               end
            end
            RAPC_F_GAP: fail_reg <= RAPC_F_ON;
            default: fail_reg <= RAPC_F_IDLE;
         endcase
      end
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         `RAPC_OFF_CTRL: rdata_next = {23'h0, board_present, ras_reg,
                                       1'b0, rcs_reg};
         `RAPC_OFF_MOM: rdata_next = {16'h0, mom_reg};
         `RAPC_OFF_DIFF: rdata_next = {24'h0, diff_reg};
         `RAPC_OFF_RELAY: rdata_next = {16'h0, relay_reg};
         `RAPC_OFF_STAT: rdata_next = {16'h0, stat_reg};
         `RAPC_OFF_VALID: rdata_next = {16'h0, valid_reg};
         `RAPC_OFF_HOLD: rdata_next = {24'h0, hold_reg};
         default:
         begin
            if (paddr >= 12'h040 && paddr < 12'h080)
               rdata_next = {22'h0, value_reg[paddr[5:2]]};
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rdata_next;
   end

   assign relay_out = relay_reg;
   assign fail_led = (fail_reg == RAPC_F_ON);
endmodule : rapc_top

// *** core/rapc_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned registers
`ifndef RAPC_REGS_SVH
`define RAPC_REGS_SVH
`define RAPC_OFF_CTRL 12'h000
`define RAPC_OFF_MOM 12'h004
`define RAPC_OFF_DIFF 12'h008
`define RAPC_OFF_CMD 12'h00C
`define RAPC_OFF_RELAY 12'h010
`define RAPC_OFF_STAT 12'h014
`define RAPC_OFF_RANGE 12'h018
`define RAPC_OFF_RDATA 12'h01C
`define RAPC_OFF_VALID 12'h020
`define RAPC_OFF_HOLD 12'h024
`define RAPC_CTRL_RCS_LSB 0
`define RAPC_CTRL_RAS_LSB 4
`define RAPC_CTRL_BOARD 8
`define RAPC_CMD_ON 16
`define RAPC_CMD_VALID 17
`define RAPC_CMD_SCAN_LSB 8
`define RAPC_CMD_PT_LSB 0
`define RAPC_RCS_MIN 3'd1
`define RAPC_RCS_MAX 3'd6
`define RAPC_RAS_MAX 4'd12
`define RAPC_RANGE_MAX 4'd9
`define RAPC_RANGE_RST 4'd0
`define RAPC_HOLD_RST 8'd2
`define RAPC_PULSE_MS 200
`define RAPC_CLK_MHZ 100
`define RAPC_PULSE_CYC (`RAPC_PULSE_MS * 1000 * `RAPC_CLK_MHZ)
`define RAPC_SEC_CYC (1000 * 1000 * `RAPC_CLK_MHZ)
`define RAPC_BLINK_CYC (25 * 1000 * 1000)
`define RAPC_BIP_ZERO 10'd499
`define RAPC_BIP_FULL 10'd999
`endif

// *** core/rapc_pkg.sv ***
// types shared by the relay and analog point logic
// assumes rapc_regs.svh supplies all numeric constants
package rapc_pkg;
   typedef enum logic [3:0] {
      RAPC_F_IDLE = 4'b0001,
      RAPC_F_ON = 4'b0010,
      RAPC_F_OFF = 4'b0100,
      RAPC_F_GAP = 4'b1000
   } rapc_fail_t;
endpackage : rapc_pkg

// *** core/rapc_range_mem.sv ***
// range-code memory, 16 entries of 5 bits, registered read
// assumes single clock, writes and clear never in conflict harmfully
`timescale 1ns/10ps
`include "rapc_regs.svh"
module rapc_range_mem
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic clr,
   input wire logic [3:0] waddr,
   input wire logic [4:0] wdata,
   input wire logic [3:0] raddr,
   output logic [4:0] rdata
);
   logic [4:0] mem [0:15];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 16; i++)
            mem[i] <= {1'b0, `RAPC_RANGE_RST};
      end
      else if (clr)
      begin
         for (int i = 0; i < 16; i++)
            mem[i] <= {1'b0, `RAPC_RANGE_RST};
      end
      else if (we)
         mem[waddr] <= wdata;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata <= 5'h00;
      else
         rdata <= mem[raddr];
   end
endmodule : rapc_range_mem

// *** sim/rapc_checker.sv ***
// port checker for rapc_top, bound into the top module
// assumes the bench shortens the pulse and blink counts
`timescale 1ns/10ps
module rapc_checker
#(
   parameter int PULSE_CYC = 20
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic board_present,
   input wire logic [15:0] relay_out,
   input wire logic fail_led
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic cmd_wr;
   logic rd_set;
   assign cmd_wr = psel & penable & pwrite & (paddr == 12'h00C);
   assign rd_set = psel & ~penable & ~pwrite;
   sequence blink_on_s;
      fail_led [*4] ##1 !fail_led;
   endsequence
   ready_high_a: assert property (pready)
      else $error("pready low");
   no_slverr_a: assert property (!pslverr)
      else $error("pslverr high");
   relay_cause_a: assert property (
      (relay_out & ~$past(relay_out)) != 16'h0000 |-> $past(cmd_wr))
      else $error("relay closed without command");
   pulse_len_a: assert property (
      $fell(relay_out[0]) && !$past(cmd_wr) |->
      $past(relay_out[0], PULSE_CYC) && !$past(relay_out[0], PULSE_CYC + 1))
      else $error("momentary pulse length wrong");
   blink_on_a: assert property ($rose(fail_led) |-> blink_on_s)
      else $error("blink on time wrong");
   fail_cause_a: assert property (
      $rose(fail_led) |-> !$past(board_present))
      else $error("fail lit with board fitted");
   unmapped_zero_a: assert property (
      rd_set && paddr == 12'h01C |=> prdata == 32'h0000_0000)
      else $error("reserved read not zero");
   rdata_hold_a: assert property (!rd_set |=> $stable(prdata))
      else $error("read data changed");
endmodule : rapc_checker
bind rapc_top rapc_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .board_present(board_present),
   .relay_out(relay_out), .fail_led(fail_led));

// *** sim/rapc_analog_board.sv ***
// analog input board model, sample depends on the scanned input
// assumes analog_sel names the input being scanned
`timescale 1ns/10ps
module rapc_analog_board
(
   input wire logic fitted,
   input wire logic [3:0] analog_sel,
   output logic [9:0] analog_sample
);
   // missing board leaves the lines pulled high
   assign analog_sample = fitted ? {analog_sel, 6'h00} : 10'h3FF;
endmodule : rapc_analog_board

// *** sim/relay_and_analog_point_control_tb.sv ***
// self-checking bench for rapc_top with an analog board model
// assumes shortened pulse, second and blink counts
`timescale 1ns/10ps
module relay_and_analog_point_control_tb;
   localparam int PC = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic board_present = 1, pready, pslverr, fail_led;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [9:0] analog_sample;
   logic [3:0] analog_sel;
   logic [15:0] relay_out;
   int bad_count = 0, num_checks = 0;
   rapc_top #(.PULSE_CYC(PC), .SEC_CYC(10), .BLINK_CYC(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .board_present(board_present),
      .analog_sample(analog_sample), .analog_sel(analog_sel),
      .relay_out(relay_out), .fail_led(fail_led));
   rapc_analog_board board (.fitted(board_present),
      .analog_sel(analog_sel), .analog_sample(analog_sample));
   initial forever #5 pclk = ~pclk;
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         bad_count++;
         summarize();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   // poll a register until it shows the value or the tries run out
   task automatic rd_exp(logic [11:0] a, logic [31:0] e, int tries);
      int n;
      n = 0;
      do
      begin
         xfer(1'b0, a, '0);
         n++;
      end
      while (rd !== e && n < tries);
      chk($sformatf("reg %h", a), e, rd);
   endtask : rd_exp
   task automatic wait_led(logic v);
      int n;
      n = 0;
      while (fail_led !== v && n < 200)
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (fail_led !== v)
      begin
         bad_count++;
         summarize();
      end
   endtask : wait_led
   task automatic t_reset();
      rd_exp(12'h024, 32'h0000_0002, 1);
      rd_exp(12'h01C, '0, 1);
      rd_exp(12'h000, 32'h0000_0100, 1);
   endtask : t_reset
   task automatic t_latched();
      for (int k = 1; k <= 6; k++)
      begin
         xfer(1'b1, 12'h000, k);
         xfer(1'b1, 12'h00C, 32'h0003_0000 | (k << 8) | k);
         xfer(1'b1, 12'h00C, 32'h0003_000F | (((k % 6) + 1) << 8));
         rd_exp(12'h010, 32'h1 << k, 1);
         xfer(1'b1, 12'h00C, 32'h0002_0000 | (k << 8) | k);
         rd_exp(12'h010, '0, 1);
      end
   endtask : t_latched
   task automatic t_moment();
      longint t0;
      int n;
      xfer(1'b1, 12'h000, 32'h0000_0001);
      xfer(1'b1, 12'h004, 32'h0000_0001);
      xfer(1'b1, 12'h024, 32'h0000_0003);
      xfer(1'b1, 12'h00C, 32'h0003_0100);
      t0 = $time;
      xfer(1'b1, 12'h00C, 32'h0002_0100);
      rd_exp(12'h010, 32'h0000_0001, 1);
      n = 0;
      while (relay_out[0] === 1'b1 && n < 100)
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("pulse", PC, ($time - t0) / 10);
      rd_exp(12'h014, 32'h0000_0001, 1);
      repeat (8) @(posedge pclk);
      rd_exp(12'h014, '0, 1);
   endtask : t_moment
   task automatic t_analog();
      xfer(1'b1, 12'h018, 32'h0000_0219);
      xfer(1'b1, 12'h000, 32'h0000_0011);
      rd_exp(12'h020, 32'h0000_FFFF, 40);
      rd_exp(12'h07C, 32'd960, 40);
      rd_exp(12'h048, 32'd128, 40);
      xfer(1'b1, 12'h018, 32'h0000_021A);
      rd_exp(12'h048, 32'd128, 40);
      xfer(1'b1, 12'h018, 32'h0000_0219);
      rd_exp(12'h048, 32'd124, 40);
      xfer(1'b1, 12'h000, 32'h0000_0051);
      rd_exp(12'h048, 32'd124, 40);
      xfer(1'b1, 12'h000, 32'h0000_00D1);
      rd_exp(12'h000, 32'h0000_0151, 1);
      xfer(1'b1, 12'h000, 32'h0000_0001);
      xfer(1'b1, 12'h000, 32'h0000_0051);
      rd_exp(12'h048, 32'd128, 40);
      xfer(1'b1, 12'h008, 32'h0000_0001);
      rd_exp(12'h020, 32'h0000_FEFF, 40);
      rd_exp(12'h060, '0, 40);
      xfer(1'b1, 12'h008, 32'h0000_00FF);
      rd_exp(12'h020, 32'h0000_00FF, 40);
      rd_exp(12'h07C, '0, 40);
   endtask : t_analog
   task automatic t_fail();
      longint t[4];
      @(posedge pclk);
      board_present <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         wait_led(1'b0);
         wait_led(1'b1);
         t[i] = $time;
      end
      chk("blink", 1, (t[1] - t[0] == t[2] - t[1]) &&
         (t[3] - t[2] > t[1] - t[0]));
      // let the lit phase finish before the fault clears
      wait_led(1'b0);
      @(posedge pclk);
      board_present <= 1'b1;
   endtask : t_fail
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_latched();
      t_moment();
      t_analog();
      t_fail();
      summarize();
   end
endmodule : relay_and_analog_point_control_tb
